// ### logic/core_pkg.sv
package core_pkg;
    // register byte addresses on the slave bus
    localparam logic [15:0] ACC_OFF = 16'hFE00;
    localparam logic [15:0] OPHI_OFF = 16'hFE01;
    localparam logic [15:0] OFSC_OFF = 16'hFE02;
    localparam logic [15:0] STS_OFF = 16'hFE06;
    localparam logic [15:0] PC_OFF = 16'hFF00;
    localparam logic [15:0] SP_OFF = 16'hFF04;
    localparam logic [15:0] CTRL_OFF = 16'hFF08;
    localparam logic [7:0] REG_RESET = 8'h00;
    // status word bits
    localparam int CF_BIT = 7;
    localparam int HC_BIT = 6;
    localparam int LKB_BIT = 3;
    localparam int VF_BIT = 2;
    localparam int P9_BIT = 1;
    localparam int PAR_BIT = 0;
    // vectors
    localparam logic [16:0] RESET_VEC = 17'h00000;
    localparam logic [16:0] VEC_G0 = 17'h00033;
    localparam logic [16:0] VEC_G1 = 17'h0003B;
    localparam logic [16:0] VEC_G2 = 17'h00043;
    localparam logic [16:0] VEC_G3 = 17'h0004B;
    localparam logic [16:0] OPT_BIG_LO = 17'h1FF00;
    localparam logic [16:0] OPT_SMALL_LO = 17'h0FF00;
    localparam logic [15:0] RAM9_TOP = 16'hFDFF;
    localparam logic [15:0] INDIR_TOP = 16'h007F;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [3:0] {
        OP_SEQ = 4'h0, OP_COND = 4'h1, OP_JUMP = 4'h2, OP_JR = 4'h3,
        OP_CALL = 4'h4, OP_CALLR = 4'h5, OP_CALLA = 4'h6, OP_RTN = 4'h7,
        OP_INT = 4'h8, OP_MULDIV = 4'h9, OP_ALU = 4'hA, OP_LOOKUP = 4'hB,
        OP_EXT = 4'hC, OP_IND = 4'hD
    } op_t;

    // sequencer: push writes 2 bytes, return reads 2 bytes
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000, ST_PUSH1 = 3'b001, ST_PUSH2 = 3'b011,
        ST_POP1 = 3'b010, ST_POP2 = 3'b110
    } seq_t;

    typedef struct packed {
        op_t op;
        logic [2:0] len;
        logic taken;
        logic [7:0] disp8;
        logic [11:0] disp12;
        logic [16:0] target;
        logic [1:0] int_group;
        logic [5:0] ind_sel;
        logic [15:0] ind_base;
        logic [23:0] mul_res;
        logic [15:0] alu_res;
        logic alu_wide;
        logic [3:0] alu_flags;
        logic [15:0] ext_lo;
    } cmd_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [8:0] wdata;
        logic we;
        logic re;
    } ram_req_t;

    typedef struct packed {
        logic [17:0] addr;
    } rom_req_t;
endpackage

// ### logic/cpu_pc_core.sv
`timescale 1ns/1ps
// Behaviour
// - interrupt loads group vector, bank flag forced to zero
// - taken conditional branch: PC plus byte count plus signed 8-bit
// - return loads PC high from (SP), low and bank from (SP-1)
// - ordinary instruction advances PC by its byte count
// - reset start fixed zero on mask part, option value on flash
// - 256-byte option area in bank 0 not fetchable as code
// - 256K program space; table lookup reads any byte in bank
// - RAM below FE00 is nine bits; status bit 1 is a plain register bit, not routed to the ninth bit
// - low 128 RAM bytes form 64 indirect registers, 17-bit for lookup
// - call or interrupt pushes low+bank at SP+1, high at SP+2
// - accumulator at FE00, eight bits, resets to zero
// - high operand byte extends accumulator in 16-bit arithmetic
// - high operand byte drives external address bits 23..16
// - high operand byte register at FE01, resets to zero
// - multiply and divide write accumulator, B and C together
// - C supplies signed offset added to indirect register
// - C register at FE02, resets to zero
// - status word at FE06, resets zero, documented bit layout
// - status bank-select bit picks word lookup ROM bank
// - PC is 17 bits plus separate bank flag
// - lookup bank 0 covers 0..1FFFF, bank 1 20000..3FFFF
// - parity bit set for odd number of ones in accumulator
module cpu_pc_core #(
    parameter bit FLASH_VARIANT = 1'b0,
    parameter bit ROM_BIG = 1'b1
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // reset option value for the flash variant
    input wire logic [16:0] option_start,
    // decoded instruction command
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire core_pkg::cmd_t cmd,
    // internal data RAM, nine bits wide
    output core_pkg::ram_req_t ram_req,
    input wire logic [8:0] ram_rdata,
    // program ROM
    output core_pkg::rom_req_t fetch_req,
    output core_pkg::rom_req_t lookup_req,
    output logic option_fault,
    // external data memory address
    output logic [23:0] ext_addr,
    // operand and effective address outputs
    output logic [15:0] wide_operand,
    output logic [15:0] ind_addr,
    // AXI4-Lite slave
    input wire logic [15:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [15:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready
);
    initial
    begin
        if (FLASH_VARIANT !== 1'b0 && FLASH_VARIANT !== 1'b1)
            $error("bad variant");
    end

    typedef struct packed {
        logic [16:0] pc;
        logic bank;
        logic [15:0] sp;
        logic [7:0] acc;
        logic [7:0] ophi;
        logic [7:0] ofsc;
        logic [7:0] status;
        core_pkg::seq_t seq;
        logic [7:0] pop_hi;
        logic [16:0] push_pc;
        logic push_bank;
        logic started;
        logic [15:0] aw_addr;
        logic aw_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic w_have;
        logic b_pend;
        logic [1:0] b_resp;
        logic r_pend;
        logic [31:0] r_data;
        logic [1:0] r_resp;
    } state_t;

    state_t state_reg;
    state_t state_next;
    logic parity;
    logic [16:0] seq_pc;
    logic bus_write;
    logic [31:0] rd_word;
    logic rd_ok;

    ////////////////////////////////////////////////////////////////////////
    // parity bit
    assign parity = ^state_reg.acc;

    assign seq_pc = state_reg.pc + 17'(state_reg.seq == core_pkg::ST_IDLE ? cmd.len : 3'd0);
    assign cmd_ready = clk_en && state_reg.started && state_reg.seq == core_pkg::ST_IDLE;

    // fetch address is bank plus 17-bit PC
    assign fetch_req.addr = {state_reg.bank, state_reg.pc};
    // option area not usable as code
    assign option_fault = !state_reg.bank && state_reg.pc >=
        (ROM_BIG ? core_pkg::OPT_BIG_LO : core_pkg::OPT_SMALL_LO) &&
        state_reg.pc <= (ROM_BIG ? 17'h1FFFF : 17'h0FFFF);

    // lookup uses 17-bit register, bank from status word
    assign lookup_req.addr = {state_reg.status[core_pkg::LKB_BIT],
        ram_rdata, cmd.ind_base[7:0]};
    assign ext_addr = {state_reg.ophi, cmd.ext_lo};
    assign wide_operand = {state_reg.ophi, state_reg.acc};
    assign ind_addr = cmd.ind_base + {{8{state_reg.ofsc[7]}}, state_reg.ofsc};

    assign s_awready = !state_reg.aw_have && !state_reg.b_pend;
    assign s_wready = !state_reg.w_have && !state_reg.b_pend;
    assign s_bvalid = state_reg.b_pend;
    assign s_bresp = state_reg.b_resp;
    assign s_arready = !state_reg.r_pend;
    assign s_rvalid = state_reg.r_pend;
    assign s_rdata = state_reg.r_data;
    assign s_rresp = state_reg.r_resp;
    assign bus_write = state_reg.aw_have && state_reg.w_have && !state_reg.b_pend;

    ////////////////////////////////////////////////////////////////////////
    // read mux
    always_comb
    begin
        rd_word = 32'h00000000;
        rd_ok = 1'b1;
        if (s_araddr == core_pkg::ACC_OFF)
            rd_word = {24'h000000, state_reg.acc};
        else if (s_araddr == core_pkg::OPHI_OFF)
            rd_word = {24'h000000, state_reg.ophi};
        else if (s_araddr == core_pkg::OFSC_OFF)
            rd_word = {24'h000000, state_reg.ofsc};
        else if (s_araddr == core_pkg::STS_OFF)
            rd_word = {24'h000000, state_reg.status[7:1], parity};
        else if (s_araddr == core_pkg::PC_OFF)
            rd_word = {14'h0000, state_reg.bank, state_reg.pc};
        else if (s_araddr == core_pkg::SP_OFF)
            rd_word = {16'h0000, state_reg.sp};
        else if (s_araddr == core_pkg::CTRL_OFF)
            rd_word = {29'h00000000, 3'(state_reg.seq)};
        else
            rd_ok = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        state_next = state_reg;
        ram_req = '0;
        if (!state_reg.started)
        begin
            state_next.started = 1'b1;
            state_next.pc = FLASH_VARIANT ? option_start : core_pkg::RESET_VEC;
        end
        // bus channels
        if (s_awvalid && s_awready)
        begin
            state_next.aw_addr = s_awaddr;
            state_next.aw_have = 1'b1;
        end
        if (s_wvalid && s_wready)
        begin
            state_next.w_data = s_wdata;
            state_next.w_strb = s_wstrb;
            state_next.w_have = 1'b1;
        end
        if (state_reg.b_pend && s_bready)
            state_next.b_pend = 1'b0;
        if (state_reg.r_pend && s_rready)
            state_next.r_pend = 1'b0;
        if (s_arvalid && s_arready)
        begin
            state_next.r_pend = 1'b1;
            state_next.r_data = rd_word;
            state_next.r_resp = rd_ok ? core_pkg::RESP_OKAY : core_pkg::RESP_SLVERR;
        end
        // instruction execution
        case (state_reg.seq)
            core_pkg::ST_IDLE:
            begin
                if (cmd_valid && cmd_ready)
                begin
                    state_next.pc = seq_pc;
                    case (cmd.op)
                        core_pkg::OP_COND:
                            if (cmd.taken)
                                state_next.pc = seq_pc + {{9{cmd.disp8[7]}}, cmd.disp8};
                        core_pkg::OP_JUMP:
                            state_next.pc = cmd.target;
                        core_pkg::OP_JR:
                            state_next.pc = state_reg.pc + 17'd2 + {{5{cmd.disp12[11]}}, cmd.disp12};
                        core_pkg::OP_CALL, core_pkg::OP_CALLR, core_pkg::OP_CALLA, core_pkg::OP_INT:
                        begin
                            state_next.push_pc = seq_pc;
                            state_next.push_bank = state_reg.bank;
                            state_next.seq = core_pkg::ST_PUSH1;
                            if (cmd.op == core_pkg::OP_CALL)
                                state_next.pc = cmd.target;
                            else if (cmd.op == core_pkg::OP_CALLR)
                                state_next.pc = state_reg.pc + 17'd2 + {{5{cmd.disp12[11]}}, cmd.disp12};
                            else if (cmd.op == core_pkg::OP_CALLA)
                                state_next.pc = state_reg.pc + 17'd1 + {9'h000, state_reg.acc};
                            else
                            begin
                                state_next.push_pc = state_reg.pc;
                                state_next.bank = 1'b0;
                                case (cmd.int_group)
                                    2'd0: state_next.pc = core_pkg::VEC_G0;
                                    2'd1: state_next.pc = core_pkg::VEC_G1;
                                    2'd2: state_next.pc = core_pkg::VEC_G2;
                                    default: state_next.pc = core_pkg::VEC_G3;
                                endcase
                            end
                        end
                        core_pkg::OP_RTN:
                        begin
                            state_next.seq = core_pkg::ST_POP1;
                        end
                        core_pkg::OP_MULDIV:
                        begin
                            state_next.acc = cmd.mul_res[7:0];
                            state_next.ophi = cmd.mul_res[15:8];
                            state_next.ofsc = cmd.mul_res[23:16];
                        end
                        core_pkg::OP_ALU:
                        begin
                            state_next.acc = cmd.alu_res[7:0];
                            if (cmd.alu_wide)
                                state_next.ophi = cmd.alu_res[15:8];
                            state_next.status[core_pkg::CF_BIT] = cmd.alu_flags[3];
                            state_next.status[core_pkg::HC_BIT] = cmd.alu_flags[2];
                            state_next.status[core_pkg::VF_BIT] = cmd.alu_flags[1];
                        end
                        // indirect register read from low RAM
                        core_pkg::OP_LOOKUP, core_pkg::OP_IND:
                        begin
                            ram_req.addr = {9'h000, cmd.ind_sel, 1'b1};
                            ram_req.re = 1'b1;
                        end
                        default:
                        begin
                        end
                    endcase
                end
            end
            // nine-bit pushes, low byte plus bank, then high bits
            core_pkg::ST_PUSH1:
            begin
                ram_req.addr = state_reg.sp + 16'd1;
                ram_req.wdata = {state_reg.push_bank, state_reg.push_pc[7:0]};
                ram_req.we = clk_en;
                state_next.seq = core_pkg::ST_PUSH2;
            end
            core_pkg::ST_PUSH2:
            begin
                ram_req.addr = state_reg.sp + 16'd2;
                ram_req.wdata = {state_reg.push_pc[16:8]};
                ram_req.we = clk_en;
                state_next.sp = state_reg.sp + 16'd2;
                state_next.seq = core_pkg::ST_IDLE;
            end
            // pop high, then low with bank
            core_pkg::ST_POP1:
            begin
                state_next.pop_hi = ram_rdata[7:0];
                state_next.pc[16] = ram_rdata[8];
                ram_req.addr = state_reg.sp;
                ram_req.re = 1'b1;
                state_next.seq = core_pkg::ST_POP2;
            end
            default:
            begin
                ram_req.addr = state_reg.sp - 16'd1;
                ram_req.re = 1'b1;
                state_next.pc = {state_reg.pc[16], state_reg.pop_hi, ram_rdata[7:0]};
                state_next.bank = ram_rdata[8];
                state_next.sp = state_reg.sp - 16'd2;
                state_next.seq = core_pkg::ST_IDLE;
            end
        endcase
        // bus write; instruction result has lower priority
        if (bus_write)
        begin
            state_next.aw_have = 1'b0;
            state_next.w_have = 1'b0;
            state_next.b_pend = 1'b1;
            state_next.b_resp = core_pkg::RESP_OKAY;
            if (state_reg.w_strb[0])
            begin
                if (state_reg.aw_addr == core_pkg::ACC_OFF)
                    state_next.acc = state_reg.w_data[7:0];
                else if (state_reg.aw_addr == core_pkg::OPHI_OFF)
                    state_next.ophi = state_reg.w_data[7:0];
                else if (state_reg.aw_addr == core_pkg::OFSC_OFF)
                    state_next.ofsc = state_reg.w_data[7:0];
                else if (state_reg.aw_addr == core_pkg::STS_OFF)
                    state_next.status = {state_reg.w_data[7:1], 1'b0};
                else if (state_reg.aw_addr == core_pkg::SP_OFF)
                    state_next.sp = {state_reg.w_data[15:8], state_reg.w_data[7:0]};
                else if (state_reg.aw_addr != core_pkg::PC_OFF && state_reg.aw_addr != core_pkg::CTRL_OFF)
                    state_next.b_resp = core_pkg::RESP_SLVERR;
            end
            else if (state_reg.aw_addr != core_pkg::ACC_OFF && state_reg.aw_addr != core_pkg::OPHI_OFF &&
                     state_reg.aw_addr != core_pkg::OFSC_OFF && state_reg.aw_addr != core_pkg::STS_OFF &&
                     state_reg.aw_addr != core_pkg::SP_OFF && state_reg.aw_addr != core_pkg::PC_OFF &&
                     state_reg.aw_addr != core_pkg::CTRL_OFF)
                state_next.b_resp = core_pkg::RESP_SLVERR;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_reg <= '0;
            state_reg.seq <= core_pkg::ST_IDLE;
            state_reg.acc <= core_pkg::REG_RESET;
            state_reg.ophi <= core_pkg::REG_RESET;
            state_reg.ofsc <= core_pkg::REG_RESET;
            state_reg.status <= core_pkg::REG_RESET;
        end
        else if (clk_en)
            state_reg <= state_next;
    end
endmodule

// ### test/cpu_pc_core_assertions.sv
`timescale 1ns/1ps
module cpu_pc_core_assertions #(
    parameter bit ROM_BIG = 1'b1
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // command port
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire core_pkg::cmd_t cmd,
    // core outputs
    input wire core_pkg::ram_req_t ram_req,
    input wire core_pkg::rom_req_t fetch_req,
    input wire logic option_fault,
    input wire logic [23:0] ext_addr,
    input wire logic [15:0] wide_operand,
    // register bus
    input wire logic s_arvalid,
    input wire logic s_arready,
    input wire logic s_rvalid,
    input wire logic s_rready,
    input wire logic [31:0] s_rdata,
    input wire logic s_bvalid,
    input wire logic s_bready,
    input wire logic [1:0] s_bresp
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    logic take;
    logic [16:0] pc, seq_pc, cond_pc, rel_pc;
    assign take = cmd_valid && cmd_ready;
    assign pc = fetch_req.addr[16:0];
    assign seq_pc = pc + 17'(cmd.len);
    assign cond_pc = seq_pc + {{9{cmd.disp8[7]}}, cmd.disp8};
    assign rel_pc = pc + 17'h00002 + {{5{cmd.disp12[11]}}, cmd.disp12};
    ////////////////////////////////////////////////////////////
    a_read_answer: assert property (s_arvalid && s_arready |=> s_rvalid)
        else $error("read answer late");
    a_read_stands: assert property (s_rvalid && s_rready |=> !s_rvalid)
        else $error("read answer repeated");
    a_write_stands: assert property (s_bvalid && s_bready |=> !s_bvalid)
        else $error("write answer repeated");
    a_seq_step: assert property (
        take && cmd.op == core_pkg::OP_SEQ |=> fetch_req.addr == {$past(fetch_req.addr[17]), $past(seq_pc)})
        else $error("sequential step wrong");
    a_cond_taken: assert property (
        take && cmd.op == core_pkg::OP_COND && cmd.taken |=> fetch_req.addr == {$past(fetch_req.addr[17]), $past(cond_pc)})
        else $error("conditional target wrong");
    a_rel_branch: assert property (
        take && cmd.op == core_pkg::op_t'(4'h3) |=> fetch_req.addr == {$past(fetch_req.addr[17]), $past(rel_pc)})
        else $error("relative target wrong");
    a_int_vector: assert property (
        take && cmd.op == core_pkg::OP_INT
        |=> fetch_req.addr == {1'b0, core_pkg::VEC_G0 + {12'h000, $past(cmd.int_group), 3'b000}})
        else $error("vector wrong");
    a_push_pair: assert property (
        take && (cmd.op == core_pkg::OP_CALL || cmd.op == core_pkg::OP_INT) |=> ram_req.we && !cmd_ready
        ##1 ram_req.we && !cmd_ready && ram_req.addr == $past(ram_req.addr) + 16'h0001)
        else $error("push order wrong");
    a_ext_addr: assert property (ext_addr == {wide_operand[15:8], cmd.ext_lo})
        else $error("external address wrong");
    a_opt_fault: assert property (
        option_fault == (!fetch_req.addr[17] && fetch_req.addr[16:8] == (ROM_BIG ? 9'h1FF : 9'h0FF)))
        else $error("option area flag wrong");
    c_interrupt: cover property (take && cmd.op == core_pkg::OP_INT);
    c_write_done: cover property (s_bvalid && s_bready);
    c_option_hit: cover property (option_fault);
endmodule

// ### test/data_ram_model.sv
`timescale 1ns/1ps
module data_ram_model (
    // clock
    input wire logic aclk,
    // request from the core
    input wire core_pkg::ram_req_t ram_req,
    output logic [8:0] ram_rdata
);
    logic [8:0] mem [0:65535];
    // unselected bus toggles so a stale value never looks valid
    logic [8:0] idle_q = 9'h155;
    always @(posedge aclk)
    begin
        if (ram_req.we)
            mem[ram_req.addr] <= ram_req.wdata;
        idle_q <= ~idle_q;
    end
    assign ram_rdata = ram_req.re ? mem[ram_req.addr] : idle_q;
endmodule

// ### test/cpu_pc_core_tb_top.sv
`timescale 1ns/1ps
module cpu_pc_core_tb_top;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic clk_en = 1'b1;
    logic [16:0] option_start = 17'h00000;
    logic cmd_valid = 1'b0;
    logic cmd_ready, option_fault;
    core_pkg::cmd_t cmd = '0;
    core_pkg::ram_req_t ram_req;
    core_pkg::rom_req_t fetch_req, lookup_req;
    logic [8:0] ram_rdata;
    logic [23:0] ext_addr;
    logic [15:0] wide_operand, ind_addr;
    logic [15:0] s_awaddr = 16'h0000, s_araddr = 16'h0000;
    logic [31:0] s_wdata = 32'h0, s_rdata;
    logic [3:0] s_wstrb = 4'hF;
    logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [1:0] s_bresp, s_rresp;
    int n_fail = 0;
    int comparisons = 0;
    always #12.5 aclk = ~aclk;
    cpu_pc_core #(.FLASH_VARIANT(1'b0), .ROM_BIG(1'b1)) dut (.aclk, .aresetn, .clk_en, .option_start,
        .cmd_valid, .cmd_ready, .cmd, .ram_req, .ram_rdata, .fetch_req, .lookup_req, .option_fault,
        .ext_addr, .wide_operand, .ind_addr, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
        .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
        .s_rdata, .s_rresp, .s_rvalid, .s_rready);
    data_ram_model ram (.aclk, .ram_req, .ram_rdata);
    ////////////////////////////////////////////////////////////
    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic final_report();
        if (n_fail == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata <= {24'h000000, d};
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_awready)
                s_awvalid <= 1'b0;
            if (s_wready)
                s_wvalid <= 1'b0;
        end
        while (!s_bvalid);
        s_bready <= 1'b0;
    endtask
    task automatic bus_rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_arready)
                s_arvalid <= 1'b0;
        end
        while (!s_rvalid);
        d = s_rdata;
        r = s_rresp;
        s_rready <= 1'b0;
    endtask
    task automatic rd_chk(input string n, input logic [15:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        bus_rd(a, d, r);
        check(n, d, e);
    endtask
    function automatic core_pkg::cmd_t mk(input logic [3:0] op, input logic [2:0] len, input logic [7:0] d8,
        input logic [11:0] d12, input logic [16:0] tg);
        core_pkg::cmd_t c;
        c = '0;
        c.op = core_pkg::op_t'(op);
        c.len = len;
        c.taken = 1'b1;
        c.disp8 = d8;
        c.disp12 = d12;
        c.target = tg;
        return c;
    endfunction
    // second wait covers a following push or pop
    task automatic step(input string n, input core_pkg::cmd_t c, input logic [17:0] e);
        @(posedge aclk);
        cmd <= c;
        cmd_valid <= 1'b1;
        do
            @(posedge aclk);
        while (!cmd_ready);
        cmd_valid <= 1'b0;
        do
            @(posedge aclk);
        while (!cmd_ready);
        #1;
        check(n, {14'h0000, fetch_req.addr}, {14'h0000, e});
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [31:0] d;
        logic [1:0] r;
        rd_chk("acc reset", core_pkg::ACC_OFF, 32'h0);
        rd_chk("b reset", core_pkg::OPHI_OFF, 32'h0);
        rd_chk("c reset", core_pkg::OFSC_OFF, 32'h0);
        rd_chk("status reset", 16'hFE06, 32'h0);
        bus_rd(16'hFE03, d, r);
        check("unmapped resp", {30'h0, r}, {30'h0, core_pkg::RESP_SLVERR});
        check("unmapped data", d, 32'h0);
        bus_wr(core_pkg::ACC_OFF, 8'hB5);
        bus_wr(core_pkg::OPHI_OFF, 8'h12);
        bus_wr(core_pkg::OFSC_OFF, 8'hFF);
        bus_wr(16'hFE06, 8'hFE);
        rd_chk("status odd", 16'hFE06, 32'hFF);
        @(posedge aclk);
        cmd.ext_lo <= 16'h3456;
        cmd.ind_base <= 16'hFE02;
        @(posedge aclk);
        #1;
        check("wide operand", {16'h0, wide_operand}, 32'h12B5);
        check("ext addr", {8'h0, ext_addr}, 32'h123456);
        check("ind addr", {16'h0, ind_addr}, 32'hFE01);
        bus_wr(core_pkg::ACC_OFF, 8'h03);
        rd_chk("status even", 16'hFE06, 32'hFE);
    endtask
    task automatic t_flow();
        step("seq", mk(4'h0, 3'h3, 8'h00, 12'h000, 17'h0), 18'h00003);
        step("cond back", mk(4'h1, 3'h2, 8'hFE, 12'h000, 17'h0), 18'h00003);
        step("jump", mk(4'h2, 3'h3, 8'h00, 12'h000, 17'h01000), 18'h01000);
        step("cond min", mk(4'h1, 3'h2, 8'h80, 12'h000, 17'h0), 18'h00F82);
        step("cond max", mk(4'h1, 3'h3, 8'h7F, 12'h000, 17'h0), 18'h01004);
        step("rel branch", mk(4'h3, 3'h2, 8'h00, 12'h800, 17'h0), 18'h00806);
        step("jump edge", mk(4'h2, 3'h3, 8'h00, 12'h000, 17'h1FEFF), 18'h1FEFF);
        check("below option", {31'h0, option_fault}, 32'h0);
        step("into option", mk(4'h0, 3'h1, 8'h00, 12'h000, 17'h0), 18'h1FF00);
        check("in option", {31'h0, option_fault}, 32'h1);
    endtask
    task automatic t_stack();
        core_pkg::cmd_t c;
        bus_wr(core_pkg::SP_OFF, 8'h11);
        step("return", mk(4'h7, 3'h1, 8'h00, 12'h000, 17'h0), 18'h30134);
        rd_chk("sp popped", core_pkg::SP_OFF, 32'h000F);
        ram.mem[16'h0010] = 9'h000;
        ram.mem[16'h0011] = 9'h000;
        step("int group 0", mk(4'h8, 3'h1, 8'h00, 12'h000, 17'h0), {1'b0, core_pkg::VEC_G0});
        check("push low", {23'h0, ram.mem[16'h0010]}, 32'h134);
        check("push high", {23'h0, ram.mem[16'h0011]}, 32'h101);
        rd_chk("sp pushed", core_pkg::SP_OFF, 32'h0011);
        for (int g = 1; g < 4; g++)
        begin
            c = mk(4'h8, 3'h1, 8'h00, 12'h000, 17'h0);
            c.int_group = 2'(g);
            step("int group", c, {1'b0, core_pkg::VEC_G0 + 17'(8 * g)});
        end
        step("call", mk(4'h4, 3'h3, 8'h00, 12'h000, 17'h00200), 18'h00200);
        step("acc call", mk(4'h6, 3'h1, 8'h00, 12'h000, 17'h0), 18'h00204);
        step("rel call", mk(4'h5, 3'h2, 8'h00, 12'h7FF, 17'h0), 18'h00A05);
        c = mk(4'h9, 3'h1, 8'h00, 12'h000, 17'h0);
        c.mul_res = 24'hC3B2A1;
        step("muldiv", c, 18'h00A06);
        rd_chk("mul acc", core_pkg::ACC_OFF, 32'hA1);
        rd_chk("mul b", core_pkg::OPHI_OFF, 32'hB2);
        rd_chk("mul c", core_pkg::OFSC_OFF, 32'hC3);
        c.op = core_pkg::OP_LOOKUP;
        c.ind_sel = 6'h08;
        @(posedge aclk);
        cmd <= c;
        cmd_valid <= 1'b1;
        #1;
        check("lookup", {14'h0, lookup_req.addr}, 32'h30100);
        @(posedge aclk);
        cmd_valid <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////
    initial
    begin
        ram.mem[16'h0010] = 9'h134;
        ram.mem[16'h0011] = 9'h101;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        t_regs();
        t_flow();
        t_stack();
        final_report();
    end
    initial
    begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        final_report();
    end
endmodule
bind cpu_pc_core cpu_pc_core_assertions #(.ROM_BIG(ROM_BIG)) chk (.aclk, .aresetn, .cmd_valid, .cmd_ready,
    .cmd, .ram_req, .fetch_req, .option_fault, .ext_addr, .wide_operand, .s_arvalid, .s_arready,
    .s_rvalid, .s_rready, .s_rdata, .s_bvalid, .s_bready, .s_bresp);
